// file: shared/fault_pkg.sv
package fault_pkg;

   // register byte offsets on the apb slave
   localparam logic [7:0]  OFS_FAULT_FLAGS        = 8'h00;
   localparam logic [7:0]  OFS_FAULT_FLAGS_SECOND = 8'h04;
   localparam logic [7:0]  OFS_WARN_FLAGS         = 8'h08;
   localparam logic [7:0]  OFS_WARN_FLAGS_SECOND  = 8'h0c;
   localparam logic [7:0]  OFS_STATUS_WORD        = 8'h10;
   localparam logic [7:0]  OFS_CONTROL_WORD       = 8'h14;
   localparam logic [7:0]  OFS_IRQ_STATUS         = 8'h18;
   localparam logic [7:0]  OFS_IRQ_MASK           = 8'h1c;
   localparam logic [7:0]  OFS_CONV_INDEX         = 8'h20;
   localparam logic [7:0]  OFS_DATA_TYPE          = 8'h24;

   // implemented bits of each word; the rest are reserved or not used
   localparam logic [31:0] FAULT_IMPL_MASK        = 32'h7fff_ffff;
   localparam logic [31:0] FAULT_SECOND_IMPL_MASK = 32'h000c_01e5;
   localparam logic [31:0] WARN_IMPL_MASK         = 32'h3fff_ffff;
   localparam logic [31:0] WARN_SECOND_IMPL_MASK  = 32'h000c_01e7;

   // named bits of the first fault word
   localparam logic [31:0] FAULT_BRAKE_CHECK      = 32'h0000_0001;
   localparam logic [31:0] FAULT_CARD_OVERTEMP    = 32'h0000_0008;
   localparam logic [31:0] FAULT_OVERCURRENT      = 32'h0000_0020;
   localparam logic [31:0] FAULT_THERMISTOR       = 32'h0000_0080;
   localparam logic [31:0] FAULT_PHASE_V_MISSING  = 32'h0010_0000;
   localparam logic [31:0] FAULT_PHASE_W_MISSING  = 32'h0020_0000;

   // control and status word bit positions
   localparam int          CTRL_ACK_BIT           = 3;
   localparam int          STAT_WARN_TOGGLE_BIT   = 7;
   localparam int          STAT_FAULT_BIT         = 3;
   localparam int          STAT_RUN_BIT           = 0;

   // interrupt status layout
   localparam int          IRQ_FAULT_ENTER        = 0;
   localparam int          IRQ_FAULT_LEAVE        = 1;
   localparam int          IRQ_WARN_CHANGE        = 2;
   localparam int          IRQ_WIDTH              = 3;

   // parameter data type codes
   localparam logic [7:0]  DT_INT16               = 8'h03;
   localparam logic [7:0]  DT_INT32               = 8'h04;
   localparam logic [7:0]  DT_UINT8               = 8'h05;
   localparam logic [7:0]  DT_UINT16              = 8'h06;
   localparam logic [7:0]  DT_UINT32              = 8'h07;
   localparam logic [7:0]  DT_VIS_STRING          = 8'h09;
   localparam logic [7:0]  DT_BYTE_STRING         = 8'h0a;
   localparam logic [7:0]  DT_STD_VALUE16         = 8'h21;
   localparam logic [7:0]  DT_BIT_SEQUENCE        = 8'h23;
   localparam logic [7:0]  DT_BYTE                = 8'h29;
   localparam logic [7:0]  DT_WORD                = 8'h2a;

   // conversion index codes (signed byte)
   localparam logic [7:0]  CONV_UNITY             = 8'h64;
   localparam logic [7:0]  CONV_SIXTIETH          = 8'h43;
   localparam logic [7:0]  CONV_POW_MIN           = 8'hfa;
   localparam logic [7:0]  CONV_POW_MAX           = 8'h06;

   // fault state machine
   typedef enum logic [1:0]
   {
      ST_RUN   = 2'b01,
      ST_FAULT = 2'b10
   } drive_state_t;

endpackage : fault_pkg

// file: rtl/conv_scale.sv
`timescale 1ns/1ps
`default_nettype none
// classifies a conversion index and a data type code
module conv_scale
   import fault_pkg::*;
(
   input  wire logic [7:0] conv_index_i,
   input  wire logic [7:0] data_type_i,
   output logic            conv_valid_o,
   output logic            conv_neg_o,
   output logic [2:0]      conv_power_o,
   output logic            dtype_valid_o
);

   // conversion index: powers -6..6, one sixtieth, unity
   always_comb
   begin
      conv_valid_o = 1'b0;
      conv_neg_o   = 1'b0;
      conv_power_o = 3'h0;
      if (conv_index_i == CONV_UNITY || conv_index_i == CONV_SIXTIETH)
      begin
         conv_valid_o = 1'b1; // RULE2
      end
      else if (!conv_index_i[7] && conv_index_i <= CONV_POW_MAX)
      begin
         conv_valid_o = 1'b1; // RULE2
         conv_power_o = conv_index_i[2:0];
      end
      else if (conv_index_i[7] && conv_index_i >= CONV_POW_MIN)
      begin
         conv_valid_o = 1'b1; // RULE2
         conv_neg_o   = 1'b1;
         conv_power_o = 3'(8'h00 - conv_index_i);
      end
   end

   // data type codes accepted on parameter exchanges
   always_comb
   begin
      case (data_type_i)
         DT_INT16, DT_INT32, DT_UINT8, DT_UINT16, DT_UINT32,
         DT_VIS_STRING, DT_BYTE_STRING, DT_STD_VALUE16,
         DT_BIT_SEQUENCE, DT_BYTE, DT_WORD:
            dtype_valid_o = 1'b1; // RULE1
         default:
            dtype_valid_o = 1'b0;
      endcase
   end

endmodule : conv_scale
`default_nettype wire

// file: rtl/fault_status.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RULE1) data type codes 3..42 identify parameters
// (RULE2) conversion index scales values by powers ten
// (RULE3) any alarm forces fault state, stops operation
// (RULE4) leave fault: cause gone and ack bit3
// (RULE5) warnings follow their conditions, no acknowledge
// (RULE6) one warning word bit per warning
// (RULE7) one alarm word bit per alarm
// (RULE8) warning change toggles status word bit 7
// (RULE9) word shows all active bits combined
// (RULE10) brake, card temp, overcurrent, thermistor bit map
// (RULE11) phase v and w missing bit map
// (RULE12) reserved bits read zero, ignore writes
module fault_status
   import fault_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // condition inputs from the drive, asynchronous levels
   input  wire logic [31:0] alarm_cond_i,
   input  wire logic [31:0] alarm2_cond_i,
   input  wire logic [31:0] warn_cond_i,
   input  wire logic [31:0] warn2_cond_i,
   // drive side
   output logic             run_enable_o,
   output logic             fault_o,
   output logic             irq_o
);

   logic [31:0]  alarm_s1, alarm_s2, alarm_s3, alarm_q;
   logic [31:0]  alarm2_s1, alarm2_s2, alarm2_s3, alarm2_q;
   logic [31:0]  warn_s1, warn_s2, warn_s3, warn_q;
   logic [31:0]  warn2_s1, warn2_s2, warn2_s3, warn2_q;
   logic [31:0]  fault_flags;
   logic [31:0]  fault_flags_second;
   logic [31:0]  warn_flags;
   logic [31:0]  warn_flags_second;
   logic         warn_toggle;
   logic         ack_req;
   logic [7:0]   conv_index;
   logic [7:0]   data_type;
   logic [IRQ_WIDTH-1:0] irq_status;
   logic [IRQ_WIDTH-1:0] irq_mask;
   logic [IRQ_WIDTH-1:0] irq_event;
   drive_state_t state;
   drive_state_t next_state;
   logic         any_alarm;
   logic         warn_changed;
   logic         access;
   logic         wr_en;
   logic         rd_en;
   logic [31:0]  next_rdata;
   logic         next_err;
   logic         conv_valid;
   logic         conv_neg;
   logic [2:0]   conv_power;
   logic         dtype_valid;
   logic [31:0]  status_word;

   // three-stage synchronisers; a bit counts once stages two and three agree
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         alarm_s1  <= 32'h0000_0000;
         alarm_s2  <= 32'h0000_0000;
         alarm_s3  <= 32'h0000_0000;
         alarm2_s1 <= 32'h0000_0000;
         alarm2_s2 <= 32'h0000_0000;
         alarm2_s3 <= 32'h0000_0000;
         warn_s1   <= 32'h0000_0000;
         warn_s2   <= 32'h0000_0000;
         warn_s3   <= 32'h0000_0000;
         warn2_s1  <= 32'h0000_0000;
         warn2_s2  <= 32'h0000_0000;
         warn2_s3  <= 32'h0000_0000;
      end
      else
      begin
         alarm_s1  <= alarm_cond_i;
         alarm_s2  <= alarm_s1;
         alarm_s3  <= alarm_s2;
         alarm2_s1 <= alarm2_cond_i;
         alarm2_s2 <= alarm2_s1;
         alarm2_s3 <= alarm2_s2;
         warn_s1   <= warn_cond_i;
         warn_s2   <= warn_s1;
         warn_s3   <= warn_s2;
         warn2_s1  <= warn2_cond_i;
         warn2_s2  <= warn2_s1;
         warn2_s3  <= warn2_s2;
      end
   end

   // per-bit filter: hold the last agreed value while stages disagree
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++)
      begin : g_filter
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               alarm_q[gi]  <= 1'b0;
               alarm2_q[gi] <= 1'b0;
               warn_q[gi]   <= 1'b0;
               warn2_q[gi]  <= 1'b0;
            end
            else
            begin
               if (alarm_s2[gi] == alarm_s3[gi])
                  alarm_q[gi] <= alarm_s3[gi];
               if (alarm2_s2[gi] == alarm2_s3[gi])
                  alarm2_q[gi] <= alarm2_s3[gi];
               if (warn_s2[gi] == warn_s3[gi])
                  warn_q[gi] <= warn_s3[gi];
               if (warn2_s2[gi] == warn2_s3[gi])
                  warn2_q[gi] <= warn2_s3[gi];
            end
         end
      end
   endgenerate

   // alarm words: each bit mirrors one cause, reserved bits forced low
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         fault_flags        <= 32'h0000_0000;
         fault_flags_second <= 32'h0000_0000;
      end
      else
      begin
         fault_flags        <= alarm_q & FAULT_IMPL_MASK;        // RULE7 RULE9 RULE10 RULE11 RULE12
         fault_flags_second <= alarm2_q & FAULT_SECOND_IMPL_MASK; // RULE7 RULE12
      end
   end

   // warning words follow their conditions with no latching
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         warn_flags        <= 32'h0000_0000;
         warn_flags_second <= 32'h0000_0000;
      end
      else
      begin
         warn_flags        <= warn_q & WARN_IMPL_MASK;         // RULE5 RULE6 RULE9 RULE12
         warn_flags_second <= warn2_q & WARN_SECOND_IMPL_MASK; // RULE5 RULE6 RULE12
      end
   end

   assign warn_changed = ((warn_q & WARN_IMPL_MASK) != warn_flags)
                      || ((warn2_q & WARN_SECOND_IMPL_MASK) != warn_flags_second);

   // status word bit 7 flips on every change of the warning set
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         warn_toggle <= 1'b0;
      else if (warn_changed)
         warn_toggle <= ~warn_toggle; // RULE8
   end

   assign any_alarm = (fault_flags != 32'h0000_0000)
                   || (fault_flags_second != 32'h0000_0000);

   // fault state: entered on any alarm, left on ack with cause cleared
   always_comb
   begin
      next_state = state;
      case (state)
         ST_RUN:
            if (any_alarm)
               next_state = ST_FAULT; // RULE3
         ST_FAULT:
            if (!any_alarm && ack_req)
               next_state = ST_RUN; // RULE4
         default:
            next_state = ST_FAULT;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state <= ST_RUN;
      else
         state <= next_state;
   end

   // drive outputs registered; operation stopped while faulted
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         run_enable_o <= 1'b0;
         fault_o      <= 1'b0;
      end
      else
      begin
         run_enable_o <= (next_state == ST_RUN); // RULE3
         fault_o      <= (next_state == ST_FAULT);
      end
   end

   // apb decode; zero wait states, so every access completes in one cycle
   assign access = psel_i && penable_i;
   assign wr_en  = access && pwrite_i;
   assign rd_en  = access && !pwrite_i;

   // acknowledge bit: a write with bit 3 set acts as a one-shot request
   // an ack written while the cause persists is dropped, not remembered
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ack_req <= 1'b0;
      else
         ack_req <= wr_en && (paddr_i == OFS_CONTROL_WORD)
                    && pwdata_i[CTRL_ACK_BIT]; // RULE4
   end

   // parameter scaling registers
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         conv_index <= CONV_UNITY;
         data_type  <= DT_WORD;
      end
      else if (wr_en && paddr_i == OFS_CONV_INDEX)
         conv_index <= pwdata_i[7:0]; // RULE2
      else if (wr_en && paddr_i == OFS_DATA_TYPE)
         data_type <= pwdata_i[7:0]; // RULE1
   end

   conv_scale u_conv_scale
   (
      .conv_index_i  (conv_index),
      .data_type_i   (data_type),
      .conv_valid_o  (conv_valid),
      .conv_neg_o    (conv_neg),
      .conv_power_o  (conv_power),
      .dtype_valid_o (dtype_valid)
   );

   // interrupt events: fault entry, fault exit, warning change
   assign irq_event[IRQ_FAULT_ENTER] = (state == ST_RUN) && (next_state == ST_FAULT);
   assign irq_event[IRQ_FAULT_LEAVE] = (state == ST_FAULT) && (next_state == ST_RUN);
   assign irq_event[IRQ_WARN_CHANGE] = warn_changed;

   // sticky status, cleared by reading it; a new event wins over the clear
   // cleared on the setup edge that captures prdata, so no event falls between
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_status <= '0;
      else if (psel_i && !penable_i && !pwrite_i && paddr_i == OFS_IRQ_STATUS)
         irq_status <= irq_event;
      else
         irq_status <= irq_status | irq_event;
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_mask <= '0;
      else if (wr_en && paddr_i == OFS_IRQ_MASK)
         irq_mask <= pwdata_i[IRQ_WIDTH-1:0];
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(irq_status & irq_mask);
   end

   // status word view
   always_comb
   begin
      status_word                       = 32'h0000_0000;
      status_word[STAT_RUN_BIT]         = (state == ST_RUN);
      status_word[STAT_FAULT_BIT]       = (state == ST_FAULT);
      status_word[STAT_WARN_TOGGLE_BIT] = warn_toggle; // RULE8
   end

   // read mux; unmapped addresses answer zero with slverr
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      if (paddr_i == OFS_FAULT_FLAGS)
         next_rdata = fault_flags; // RULE9
      else if (paddr_i == OFS_FAULT_FLAGS_SECOND)
         next_rdata = fault_flags_second;
      else if (paddr_i == OFS_WARN_FLAGS)
         next_rdata = warn_flags;
      else if (paddr_i == OFS_WARN_FLAGS_SECOND)
         next_rdata = warn_flags_second;
      else if (paddr_i == OFS_STATUS_WORD)
         next_rdata = status_word;
      else if (paddr_i == OFS_CONTROL_WORD)
         next_rdata = 32'h0000_0000;
      else if (paddr_i == OFS_IRQ_STATUS)
         next_rdata = {{(32-IRQ_WIDTH){1'b0}}, irq_status};
      else if (paddr_i == OFS_IRQ_MASK)
         next_rdata = {{(32-IRQ_WIDTH){1'b0}}, irq_mask};
      else if (paddr_i == OFS_CONV_INDEX)
         next_rdata = {16'h0000, conv_valid, conv_neg, 3'h0, conv_power,
                       conv_index};
      else if (paddr_i == OFS_DATA_TYPE)
         next_rdata = {23'h000000, dtype_valid, data_type};
      else
         next_err = 1'b1;
   end

   // answer in the access phase; pready registered, high one cycle after setup
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o  <= psel_i && !penable_i;
         prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? next_rdata : 32'h0000_0000;
         pslverr_o <= psel_i && !penable_i && next_err;
      end
   end

endmodule : fault_status
`default_nettype wire

// file: verification/fault_status_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fault_status_checker
   import fault_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic [31:0] alarm_cond_i,
   input wire logic [31:0] alarm2_cond_i,
   input wire logic [31:0] warn_cond_i,
   input wire logic [31:0] warn2_cond_i,
   input wire logic        run_enable_o,
   input wire logic        fault_o,
   input wire logic        irq_o
);
   logic ack_wr;
   logic alarm_any;
   logic rd_done;
   // acknowledge as taken by the slave
   assign ack_wr = pready_o && pwrite_i && paddr_i == OFS_CONTROL_WORD && pwdata_i[CTRL_ACK_BIT];
   // unused alarm bits must not trip the drive
   assign alarm_any = |(alarm_cond_i & FAULT_IMPL_MASK) || |(alarm2_cond_i & FAULT_SECOND_IMPL_MASK);
   assign rd_done = pready_o && !pwrite_i;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   a_fault_stops_run: assert property (fault_o |-> !run_enable_o)
      else $error("run enabled in fault state");
   a_alarm_trips_fault: assert property (alarm_any [*8] |=> fault_o)
      else $error("alarm held without fault state");
   a_exit_needs_ack: assert property ($fell(fault_o) |->
      $past(ack_wr, 1) || $past(ack_wr, 2) || $past(ack_wr, 3) || $past(ack_wr, 4))
      else $error("fault left without acknowledge");
   a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_data_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data outside access");
   a_err_data_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
      else $error("error response with data");
   a_fault_resv_zero: assert property (rd_done && paddr_i == OFS_FAULT_FLAGS |->
      (prdata_o & ~FAULT_IMPL_MASK) == 32'h0)
      else $error("unused fault bit set");
   a_warn2_resv_zero: assert property (rd_done && paddr_i == OFS_WARN_FLAGS_SECOND |->
      (prdata_o & ~WARN_SECOND_IMPL_MASK) == 32'h0)
      else $error("unused warning bit set");
   a_ctrl_reads_zero: assert property (rd_done && paddr_i == OFS_CONTROL_WORD |-> prdata_o == 32'h0)
      else $error("control word read back");

   c_fault_enter: cover property ($rose(fault_o));
   c_fault_leave: cover property ($fell(fault_o));
   c_slave_error: cover property (pslverr_o);
   c_irq_raised: cover property ($rose(irq_o));
endmodule : fault_status_checker
`default_nettype wire

// file: verification/fieldbus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// remote master: reads status, writes control over apb
module fieldbus_master_model
   import fault_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o
);
   initial
   begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
   end

   // one transfer; request held until ready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge clock_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clock_i);
      penable_o <= 1'b1;
      @(posedge clock_i iff pready_i);
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // released bus shows garbage, not the last value
      paddr_o <= ~a;
      pwdata_o <= ~d;
   endtask : xfer

   // acknowledge pending alarms through control bit 3
   task automatic ack_fault;
      logic [31:0] rd;
      logic        err;
      xfer(1'b1, OFS_CONTROL_WORD, 32'h0000_0008, rd, err);
   endtask : ack_fault
endmodule : fieldbus_master_model
`default_nettype wire

// file: verification/test_fault_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_fault_status;
   import fault_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_n_i;
   logic        psel, penable, pwrite, pready, pslverr, run_en, fault, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, alarm, alarm2, warn, warn2, rd;
   logic        err, s0;
   int          err_count = 0;
   int          cmp_count = 0;
   logic [7:0]  codes [11] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a,
                               8'h21, 8'h23, 8'h29, 8'h2a};
   logic [31:0] amap [6] = '{32'h1, 32'h8, 32'h20, 32'h80, 32'h0010_0000, 32'h0020_0000};

   always #2 clock_i = ~clock_i;

   fault_status u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .alarm_cond_i(alarm), .alarm2_cond_i(alarm2),
      .warn_cond_i(warn), .warn2_cond_i(warn2), .run_enable_o(run_en), .fault_o(fault),
      .irq_o(irq));
   fieldbus_master_model u_master (.clock_i(clock_i), .prdata_i(prdata), .pready_i(pready),
      .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // masked register read compared against expectation
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
      u_master.xfer(1'b0, a, 32'h0, rd, err);
      chk(what, rd & m, exp);
   endtask : rdc

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_master.xfer(1'b1, a, d, rd, err);
   endtask : wr

   // condition inputs pass a synchronizer and filter first
   task automatic settle;
      repeat (10) @(posedge clock_i);
   endtask : settle

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (20000) @(posedge clock_i);
      err_count++;
      end_of_test();
   end

   initial
   begin
      rst_n_i = 1'b0;
      {alarm, alarm2, warn, warn2} = '0;
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rdc("conv reset", OFS_CONV_INDEX, 32'h80ff, 32'h8064);
      rdc("dtype reset", OFS_DATA_TYPE, 32'h1ff, 32'h12a);
      // every listed type code, then two unlisted ones
      foreach (codes[i])
      begin
         wr(OFS_DATA_TYPE, {24'h0, codes[i]});
         rdc("dtype", OFS_DATA_TYPE, 32'h1ff, {23'h0, 1'b1, codes[i]});
      end
      wr(OFS_DATA_TYPE, 32'h08);
      rdc("dtype bad", OFS_DATA_TYPE, 32'h100, 32'h0);
      wr(OFS_DATA_TYPE, 32'h22);
      rdc("dtype bad", OFS_DATA_TYPE, 32'h100, 32'h0);
      for (int n = -6; n <= 6; n++)
      begin
         wr(OFS_CONV_INDEX, {24'h0, 8'(n)});
         rdc("conv", OFS_CONV_INDEX, 32'hc7ff,
             {16'h0, 1'b1, n < 0, 3'h0, 3'(n < 0 ? -n : n), 8'(n)});
      end
      wr(OFS_CONV_INDEX, 32'h43);
      rdc("conv 1/60", OFS_CONV_INDEX, 32'h80ff, 32'h8043);
      wr(OFS_CONV_INDEX, 32'h07);
      rdc("conv bad", OFS_CONV_INDEX, 32'h8000, 32'h0);
      wr(OFS_CONV_INDEX, 32'hf9);
      rdc("conv bad", OFS_CONV_INDEX, 32'h8000, 32'h0);
      // each named alarm alone trips the drive
      foreach (amap[i])
      begin
         alarm <= amap[i];
         settle();
         rdc("alarm word", OFS_FAULT_FLAGS, 32'hffff_ffff, amap[i]);
         chk("fault", {fault, run_en}, 32'h2);
         alarm <= 32'h0;
         settle();
         u_master.ack_fault();
         settle();
      end
      alarm <= 32'h8030_00a9;
      alarm2 <= 32'hffff_ffff;
      settle();
      rdc("alarm sum", OFS_FAULT_FLAGS, 32'hffff_ffff, 32'h0030_00a9);
      rdc("alarm2", OFS_FAULT_FLAGS_SECOND, 32'hffff_ffff, 32'h000c_01e5);
      wr(OFS_FAULT_FLAGS, 32'h0);
      rdc("alarm ro", OFS_FAULT_FLAGS, 32'hffff_ffff, 32'h0030_00a9);
      rdc("status fault", OFS_STATUS_WORD, 32'h9, 32'h8);
      u_master.ack_fault();
      settle();
      chk("ack early", fault, 1'b1);
      {alarm, alarm2} <= '0;
      settle();
      rdc("alarm gone", OFS_FAULT_FLAGS, 32'hffff_ffff, 32'h0);
      chk("latched", {fault, run_en}, 32'h2);
      u_master.ack_fault();
      settle();
      chk("resumed", {fault, run_en}, 32'h1);
      rdc("ctrl wo", OFS_CONTROL_WORD, 32'hffff_ffff, 32'h0);
      u_master.xfer(1'b0, 8'h40, 32'h0, rd, err);
      chk("unmapped err", {31'h0, err}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      // warning change flips status bit 7, raises masked irq
      u_master.xfer(1'b0, OFS_IRQ_STATUS, 32'h0, rd, err);
      wr(OFS_IRQ_MASK, 32'h4);
      u_master.xfer(1'b0, OFS_STATUS_WORD, 32'h0, rd, err);
      s0 = rd[STAT_WARN_TOGGLE_BIT];
      {warn, warn2} <= '1;
      settle();
      rdc("warn", OFS_WARN_FLAGS, 32'hffff_ffff, 32'h3fff_ffff);
      rdc("warn2", OFS_WARN_FLAGS_SECOND, 32'hffff_ffff, 32'h000c_01e7);
      rdc("toggle", OFS_STATUS_WORD, 32'h81, {24'h0, ~s0, 7'h1});
      chk("irq on", irq, 1'b1);
      rdc("irq status", OFS_IRQ_STATUS, 32'h7, 32'h4);
      settle();
      chk("irq cleared", irq, 1'b0);
      wr(OFS_IRQ_MASK, 32'h0);
      {warn, warn2} <= '0;
      settle();
      chk("irq masked", irq, 1'b0);
      rdc("warn clear", OFS_WARN_FLAGS, 32'hffff_ffff, 32'h0);
      rdc("toggle back", OFS_STATUS_WORD, 32'h81, {24'h0, s0, 7'h1});
      wr(OFS_IRQ_MASK, 32'h4);
      settle();
      chk("irq unmasked", irq, 1'b1);
      end_of_test();
   end
endmodule : test_fault_status

bind fault_status fault_status_checker u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .alarm_cond_i(alarm_cond_i), .alarm2_cond_i(alarm2_cond_i), .warn_cond_i(warn_cond_i),
   .warn2_cond_i(warn2_cond_i), .run_enable_o(run_enable_o), .fault_o(fault_o),
   .irq_o(irq_o));
`default_nettype wire
